/* sadc_pkg.sv */
// What this block does
// [RULE1] A valid read address starts an analog-to-digital conversion.
// [RULE2] Conversion launches at the acknowledge clock fall, runs while the old result shifts.
// [RULE3] Trigger samples the selected channel, then resolves eight bits by successive approximation.
// [RULE4] Differential channels give a two's complement result.
// [RULE5] Each result waits in the conversion data register until sent.
// [RULE6] With auto-advance set, the next channel is selected after each conversion.
// [RULE7] First byte of a read is the result from the previous read.
// [RULE8] After reset the first byte read is 80 hex.
// [RULE9] One conversion per byte read; no free-running conversions.
// [RULE10] Internal oscillator clocks conversions and buffer refresh, visible on its pin.
// [RULE11] External clock select high tri-states the oscillator pin and uses its input.
// [RULE12] Master sends the address after start; last bit chooses direction.
// [RULE13] A write ends at stop or a repeated start.
// [RULE14] One bit per clock pulse; data stays stable while clock is high.
// [RULE15] Idle high; data fall with clock high is start, rise is stop.
// [RULE16] Master starts only on an idle bus.
// [RULE17] Every byte is followed by one acknowledge bit on an extra clock pulse.
// [RULE18] As receiver the device acknowledges every byte, address included.
// [RULE19] Master acknowledges read bytes and withholds it on the last one.
// [RULE20] Acknowledger holds data low through the acknowledge clock high phase.
// [RULE21] On a withheld acknowledge the transmitter releases the data line.
// [RULE22] Bus clock at most 100 kHz; spikes up to 100 ns are rejected.
// [RULE23] Second byte written is the control byte.
// [RULE24] Third byte written is the output converter data value.
// [RULE25] Nonexistent channel maps to highest valid; auto-advance then wraps to zero.
// [RULE26] Reset clears the control byte, disabling output converter and oscillator.
// [RULE27] Direction bit one means read, zero means write.
package sadc_pkg;
  localparam int CLK_PS = 5000;
  localparam int SPIKE_NS = 100;
  localparam int SPIKE_CYC = (SPIKE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [4:0] SPIKE_LAST = 5'(SPIKE_CYC - 1);
  localparam logic [3:0] OSC_LAST = 4'hf;
  localparam logic [5:0] REFRESH_LAST = 6'h3f;
  // Fixed address part, value arbitrary
  localparam logic [3:0] ADDR_FIXED = 4'h5;
  localparam logic [7:0] ADC_RESET = 8'h80;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DAC_RESET = 8'h00;
  localparam int CTRL_AOE = 6;
  localparam int CTRL_AINC = 2;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DAC = 8'h04;
  localparam logic [7:0] REG_ADC = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_RD_ACK = 3'b110,
    ST_WAIT = 3'b111
  } sadc_bus_e;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } sadc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sadc_axi_rsp_s;

  typedef struct packed {
    logic [7:0] dac_code;
    logic aout_en;
    logic hold;
    logic sample;
    logic [1:0] channel;
    logic diff;
    logic refresh;
  } sadc_ana_s;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [1:0] flt;
    logic [1:0] flt_p;
    logic [1:0][4:0] fcnt;
    sadc_bus_e st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic rd;
    logic acked;
    logic wr_idx;
    logic sda_low;
    logic [7:0] ctrl;
    logic [7:0] dac;
    logic [7:0] adc;
    logic busy;
    logic [2:0] sbit;
    logic [7:0] trial;
    logic [1:0] cch;
    logic cdiff;
    logic [3:0] odiv;
    logic osc_lvl;
    logic osc_p;
    logic [5:0] rcnt;
    logic aw_have;
    logic [7:0] aw_a;
    logic w_have;
    logic [7:0] w_d;
    logic w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    sadc_ana_s ana;
  } sadc_state_s;
endpackage

/* sadc_top.sv */
`timescale 1ns/1ps
module sadc_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] ADDR_PINS,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic OSCILLATOR_PIN_IN,
  output logic OSCILLATOR_PIN_OUT,
  output logic OSCILLATOR_PIN_OE_N,
  input wire logic EXTERNAL_CLOCK_SELECT,
  input wire logic COMPARATOR,
  output sadc_pkg::sadc_ana_s ANALOG,
  input wire sadc_pkg::sadc_axi_req_s S_AXI_REQ,
  output sadc_pkg::sadc_axi_rsp_s S_AXI_RSP
);
  import sadc_pkg::*;

  sadc_state_s q;
  sadc_state_s n;
  logic [7:0] raw;
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic osc_run;
  logic itick;
  logic tick;
  logic keep;
  logic [7:0] sar_res;
  logic sar_done;
  logic trig;
  logic [1:0] next_ch;
  logic ctrl_wr;
  logic awready;
  logic wready;
  logic arready;

  // ***************************************************
  // Channel decoding
  // ***************************************************
  function automatic logic [1:0] ch_max(input logic [7:0] c);
    case (c[5:4])
      2'h0: return 2'h3;
      2'h3: return 2'h1;
      default: return 2'h2;
    endcase
  endfunction

  function automatic logic [1:0] eff_ch(input logic [7:0] c);
    return (c[1:0] > ch_max(c)) ? ch_max(c) : c[1:0]; // [RULE25]
  endfunction

  function automatic logic is_diff(input logic [7:0] c);
    return (c[5:4] == 2'h1) || (c[5:4] == 2'h3) || (c[5:4] == 2'h2 && eff_ch(c) == 2'h2);
  endfunction

  // ***************************************************
  // Line events
  // ***************************************************
  assign raw = {ADDR_PINS, COMPARATOR, EXTERNAL_CLOCK_SELECT, OSCILLATOR_PIN_IN, SDA_IN, SCL};
  assign scl = q.flt[0];
  assign scl_rise = q.flt[0] & ~q.flt_p[0];
  assign scl_fall = ~q.flt[0] & q.flt_p[0];
  assign start = q.flt[0] & q.flt_p[0] & q.flt_p[1] & ~q.flt[1]; // [RULE15]
  assign stop = q.flt[0] & q.flt_p[0] & ~q.flt_p[1] & q.flt[1]; // [RULE15]
  assign trig = scl_fall & ((q.st == ST_ADDR_ACK & q.rd) | (q.st == ST_RD_ACK & q.acked));

  // Oscillator only runs when something needs it, to save power
  assign osc_run = q.busy | q.ctrl[CTRL_AOE]; // [RULE26]
  assign itick = osc_run & (q.odiv == OSC_LAST);
  assign tick = q.s2[3] ? (q.s2[2] & ~q.osc_p) : itick; // [RULE11]

  assign keep = q.s2[4];
  assign sar_res = keep ? q.trial : (q.trial & ~(8'h01 << q.sbit));
  assign sar_done = q.busy & tick & (q.sbit == 3'h0) & ~trig;
  assign next_ch = (q.cch == ch_max(q.ctrl)) ? 2'h0 : q.cch + 2'h1;
  assign ctrl_wr = (q.st == ST_WR & scl_fall & q.bitcnt == 4'h8 & ~q.wr_idx)
    | (q.aw_have & q.w_have & ~q.bvalid & q.aw_a == REG_CTRL & q.w_s);

  assign awready = ~q.aw_have & ~q.bvalid;
  assign wready = ~q.w_have & ~q.bvalid;
  assign arready = ~q.rvalid;

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb
  begin
    n = q;
    n.s1 = raw;
    n.s2 = q.s1;
    n.flt_p = q.flt;
    n.ana.sample = 1'b0;
    n.ana.refresh = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      // Spike filter: a level must persist before it is believed
      if (q.s2[i] == q.flt[i])
        n.fcnt[i] = 5'h00;
      else if (q.fcnt[i] == SPIKE_LAST)
      begin
        n.flt[i] = q.s2[i]; // [RULE22]
        n.fcnt[i] = 5'h00;
      end
      else
        n.fcnt[i] = q.fcnt[i] + 5'h01;
    end

    case (q.st)
      ST_IDLE:
      begin
      end
      ST_ADDR, ST_WR:
      begin
        if (scl_rise)
        begin
          n.shift = {q.shift[6:0], q.flt[1]}; // [RULE14]
          n.bitcnt = q.bitcnt + 4'h1;
        end
        else if (scl_fall && q.bitcnt == 4'h8)
        begin
          n.bitcnt = 4'h0;
          if (q.st == ST_WR)
          begin
            if (!q.wr_idx)
              n.ctrl = q.shift; // [RULE23]
            else
              n.dac = q.shift; // [RULE24]
            n.wr_idx = 1'b1;
            n.st = ST_WR_ACK;
            n.sda_low = 1'b1; // [RULE18]
          end
          else if (q.shift[7:1] == {ADDR_FIXED, q.s2[7:5]}) // [RULE12]
          begin
            n.rd = q.shift[0]; // [RULE27]
            n.st = ST_ADDR_ACK;
            n.sda_low = 1'b1; // [RULE18]
          end
          else
            n.st = ST_WAIT;
        end
      end
      ST_ADDR_ACK, ST_WR_ACK:
      begin
        if (scl_fall)
        begin
          n.sda_low = 1'b0; // [RULE20]
          n.wr_idx = (q.st == ST_WR_ACK);
          n.st = ST_WR;
          if (q.st == ST_ADDR_ACK && q.rd)
          begin
            n.tx = q.adc; // [RULE7]
            n.sda_low = ~q.adc[7];
            n.st = ST_RD;
          end
        end
      end
      ST_RD:
      begin
        if (scl_rise)
          n.bitcnt = q.bitcnt + 4'h1;
        else if (scl_fall)
        begin
          if (q.bitcnt == 4'h8)
          begin
            n.sda_low = 1'b0;
            n.bitcnt = 4'h0;
            n.st = ST_RD_ACK; // [RULE17]
          end
          else
          begin
            n.tx = {q.tx[6:0], 1'b0};
            n.sda_low = ~q.tx[6];
          end
        end
      end
      ST_RD_ACK:
      begin
        if (scl_rise)
          n.acked = ~q.flt[1]; // [RULE19]
        else if (scl_fall)
        begin
          if (q.acked)
          begin
            n.tx = q.adc;
            n.sda_low = ~q.adc[7];
            n.st = ST_RD;
          end
          else
            n.st = ST_WAIT; // [RULE21]
        end
      end
      ST_WAIT:
      begin
      end
      default:
        n.st = ST_IDLE;
    endcase

    if (start)
    begin
      n.st = ST_ADDR;
      n.bitcnt = 4'h0;
      n.sda_low = 1'b0;
    end
    else if (stop)
    begin
      n.st = ST_IDLE; // [RULE13]
      n.sda_low = 1'b0;
    end

    // ***************************************************
    // Successive approximation
    // ***************************************************
    if (q.busy && tick)
    begin
      // First tick only settles: the comparator path lags the trial code by three cycles
      if (q.trial == 8'h00)
        n.trial = 8'h80; // [RULE3]
      else if (sar_done)
      begin
        n.busy = 1'b0;
        n.adc = q.cdiff ? (sar_res ^ 8'h80) : sar_res; // [RULE4]
        if (q.ctrl[CTRL_AINC])
          n.ctrl[1:0] = next_ch; // [RULE6]
      end
      else
      begin
        n.trial = sar_res | (8'h01 << (q.sbit - 3'h1)); // [RULE3]
        n.sbit = q.sbit - 3'h1;
      end
    end
    // A late trigger restarts an unfinished conversion
    if (trig)
    begin
      n.busy = 1'b1; // [RULE1]
      n.sbit = 3'h7;
      n.trial = 8'h00;
      n.cch = eff_ch(q.ctrl);
      n.cdiff = is_diff(q.ctrl);
      n.ana.sample = 1'b1; // [RULE2]
    end

    // ***************************************************
    // Oscillator and buffer refresh
    // ***************************************************
    n.osc_p = q.s2[2];
    if (osc_run)
      n.odiv = itick ? 4'h0 : q.odiv + 4'h1;
    if (itick)
      n.osc_lvl = ~q.osc_lvl; // [RULE10]
    if (q.ctrl[CTRL_AOE] && tick)
    begin
      n.rcnt = q.rcnt + 6'h01;
      n.ana.refresh = (q.rcnt == REFRESH_LAST); // [RULE10]
    end

    // ***************************************************
    // Register slave
    // ***************************************************
    if (S_AXI_REQ.awvalid && awready)
    begin
      n.aw_have = 1'b1;
      n.aw_a = S_AXI_REQ.awaddr[7:0];
    end
    if (S_AXI_REQ.wvalid && wready)
    begin
      n.w_have = 1'b1;
      n.w_d = S_AXI_REQ.wdata[7:0];
      n.w_s = S_AXI_REQ.wstrb[0];
    end
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (q.aw_a)
        REG_CTRL: if (q.w_s) n.ctrl = q.w_d;
        REG_DAC: if (q.w_s) n.dac = q.w_d;
        REG_ADC, REG_STAT:
        begin
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    else if (q.bvalid && S_AXI_REQ.bready)
      n.bvalid = 1'b0;

    if (S_AXI_REQ.arvalid && arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (S_AXI_REQ.araddr[7:0])
        REG_CTRL: n.rdata = {24'h0, q.ctrl};
        REG_DAC: n.rdata = {24'h0, q.dac};
        REG_ADC: n.rdata = {24'h0, q.adc};
        REG_STAT: n.rdata = {28'h0, q.s2[3], q.busy, eff_ch(q.ctrl)};
        default:
        begin
          n.rdata = 32'h0;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (q.rvalid && S_AXI_REQ.rready)
      n.rvalid = 1'b0;

    n.ana.dac_code = n.busy ? n.trial : n.dac;
    n.ana.aout_en = n.ctrl[CTRL_AOE]; // [RULE26]
    n.ana.hold = n.busy;
    n.ana.channel = n.busy ? n.cch : eff_ch(n.ctrl);
    n.ana.diff = n.busy ? n.cdiff : is_diff(n.ctrl);
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      q <= '0;
      q.flt <= 2'h3;
      q.flt_p <= 2'h3;
      q.st <= ST_IDLE;
      q.ctrl <= CTRL_RESET; // [RULE26]
      q.dac <= DAC_RESET;
      q.adc <= ADC_RESET; // [RULE8]
    end
    else
      q <= n;
  end

  // Open drain: only ever pull low
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = ~q.sda_low;
  assign OSCILLATOR_PIN_OUT = q.osc_lvl;
  assign OSCILLATOR_PIN_OE_N = q.s2[3]; // [RULE11]
  assign ANALOG = q.ana;
  assign S_AXI_RSP = '{awready: awready, wready: wready, bvalid: q.bvalid, bresp: q.bresp,
    arready: arready, rvalid: q.rvalid, rdata: q.rdata, rresp: q.rresp};

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence seq_read_addr_ack;
    q.st == ST_ADDR_ACK && q.rd && scl_fall;
  endsequence

  sequence seq_last_step;
    sar_done;
  endsequence

  chk_read_trigger: assert property (seq_read_addr_ack |=> q.busy && q.ana.hold) // [RULE1]
    else $error("read address did not start a conversion");
  chk_launch_edge: assert property ($rose(q.busy) |-> $past(scl_fall) && q.ana.sample) // [RULE2]
    else $error("conversion launched off the acknowledge fall");
  chk_sar_finish: assert property (seq_last_step |=> !q.busy ##1 !q.busy || q.ana.sample) // [RULE3]
    else $error("conversion did not finish after last step");
  chk_diff_code: assert property (seq_last_step and q.cdiff |=> q.adc == ($past(sar_res) ^ 8'h80)) // [RULE4]
    else $error("differential result not two's complement");
  chk_adc_hold: assert property (!sar_done |=> $stable(q.adc)) // [RULE5]
    else $error("conversion register changed without a result");
  chk_auto_adv: assert property (sar_done && q.ctrl[CTRL_AINC] && !ctrl_wr |=> q.ctrl[1:0] == $past(next_ch)) // [RULE6]
    else $error("channel did not advance");
  chk_first_byte: assert property (seq_read_addr_ack |=> q.tx == $past(q.adc) ##1 q.st == ST_RD) // [RULE7]
    else $error("first byte is not the previous result");
  chk_reset_80: assert property ($past(RST) |-> q.adc == ADC_RESET && q.ctrl == CTRL_RESET) // [RULE8]
    else $error("reset values wrong");
  chk_ack_drive: assert property ((q.st == ST_ADDR_ACK || q.st == ST_WR_ACK) |-> !SDA_OE_N) // [RULE18]
    else $error("receiver did not acknowledge");
  chk_nack_release: assert property (q.st == ST_WAIT |-> SDA_OE_N) // [RULE21]
    else $error("data line held after withheld acknowledge");
  chk_sda_stable: assert property (scl && $past(scl) && !start && !stop |-> $stable(q.sda_low)) // [RULE14]
    else $error("data changed while clock high");
  chk_start_detect: assert property (start |=> q.st == ST_ADDR && q.bitcnt == 4'h0) // [RULE15]
    else $error("start condition missed");
endmodule

/* sadc_bus_master.sv */
`timescale 1ns/1ps
module sadc_bus_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ********************
  // Two-wire bus master
  // ********************
  // Compressed timing: quarter bit stays above the spike filter, far above 100 kHz
  localparam int Q = 256;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Begun from released lines; data falls while clock high
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // Data moves only while clock low
  task automatic xbit(input logic b, output logic r);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  // Eight bits, then the acknowledge slot
  task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(d[i], b);
      q = {q[6:0], b};
    end
    xbit(ai, ao);
  endtask
endmodule

/* test_serial_adc_read_sequencer.sv */
`timescale 1ns/1ps
module test_serial_adc_read_sequencer;
  import sadc_pkg::*;
  localparam logic [2:0] PINS = 3'h3;
  localparam logic [7:0] AW = {ADDR_FIXED, PINS, 1'b0};
  localparam logic [7:0] AR = {ADDR_FIXED, PINS, 1'b1};
  localparam logic [7:0] ABAD = {ADDR_FIXED, 3'h2, 1'b0};
  logic clk;
  logic rst;
  logic cmp_q;
  logic ext_sel;
  logic sda_oe_n;
  logic sda_out;
  logic osc_out;
  logic osc_oe_n;
  logic scl;
  logic m_low;
  wire sda_w;
  sadc_ana_s ana;
  sadc_axi_req_s req;
  sadc_axi_rsp_s rsp;
  logic [7:0] vin [4];
  logic [3:0] ocnt;
  int err_total;
  int checks;
  // ********************
  // Wiring and partner
  // ********************
  // Pull-up unless a party pulls low
  assign sda_w = ~(m_low | (~sda_oe_n & ~sda_out));
  // Comparator: selected input against the trial code
  always @(posedge clk)
    cmp_q <= vin[ana.channel] >= ana.dac_code;
  // External conversion clock, used once the select pin is high
  always @(posedge clk)
    ocnt <= rst ? 4'h0 : ocnt + 4'h1;
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  sadc_bus_master u_mst (.scl(scl), .sda_low(m_low), .sda(sda_w));
  sadc_top u_dut (.CLK(clk), .RST(rst), .ADDR_PINS(PINS), .SCL(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .OSCILLATOR_PIN_IN(ocnt[3]), .OSCILLATOR_PIN_OUT(osc_out),
    .OSCILLATOR_PIN_OE_N(osc_oe_n), .EXTERNAL_CLOCK_SELECT(ext_sel), .COMPARATOR(cmp_q),
    .ANALOG(ana), .S_AXI_REQ(req), .S_AXI_RSP(rsp));
  // ********************
  // Tasks
  // ********************
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hang();
    err_total++;
    conclude();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
        break;
    end
    req.bready <= 1'b0;
    if (n == 100)
      hang();
    check(rsp.bresp, er);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
        break;
    end
    req.rready <= 1'b0;
    if (n == 100)
      hang();
    check(rsp.rdata, e);
    check(rsp.rresp, er);
  endtask
  // Write bytes read back as driven; reads send all ones
  task automatic xfer(input logic [7:0] d, input logic ai, input logic [7:0] eq, input logic ea);
    logic [7:0] q;
    logic ao;
    u_mst.xbyte(d, ai, q, ao);
    check(q, eq);
    check(ao, ea);
  endtask
  // ********************
  // Sequence
  // ********************
  initial
  begin
    logic o;
    int n;
    rst = 1'b1;
    req = '0;
    req.wstrb = 4'h1;
    ext_sel = 1'b0;
    vin = '{8'h30, 8'h61, 8'h92, 8'hc3};
    err_total = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    rdc(32'h00, 32'h00, RESP_OKAY);
    rdc(32'h04, 32'h00, RESP_OKAY);
    rdc(32'h10, 32'h00, RESP_SLVERR);
    wrc(32'h20, 32'h01, RESP_SLVERR);
    u_mst.start();
    xfer(AW, 1'b1, AW, 1'b0);
    xfer(8'h44, 1'b1, 8'h44, 1'b0);
    xfer(8'ha5, 1'b1, 8'ha5, 1'b0);
    u_mst.start();
    xfer(ABAD, 1'b1, ABAD, 1'b1);
    u_mst.stop();
    rdc(32'h00, 32'h44, RESP_OKAY);
    rdc(32'h04, 32'ha5, RESP_OKAY);
    check(ana.aout_en, 1'b1);
    o = osc_out;
    for (n = 0; n < 40 && osc_out === o; n++)
      @(posedge clk);
    check(osc_out !== o, 1'b1);
    check(osc_oe_n, 1'b0);
    u_mst.start();
    xfer(AR, 1'b1, AR, 1'b0);
    repeat (40) @(posedge clk);
    check(ana.hold, 1'b1);
    xfer(8'hff, 1'b0, 8'h80, 1'b0);
    xfer(8'hff, 1'b0, 8'h30, 1'b0);
    xfer(8'hff, 1'b1, 8'h61, 1'b1);
    check(sda_oe_n, 1'b1);
    u_mst.stop();
    u_mst.start();
    xfer(AR, 1'b1, AR, 1'b0);
    xfer(8'hff, 1'b0, 8'h92, 1'b0);
    xfer(8'hff, 1'b0, 8'hc3, 1'b0);
    xfer(8'hff, 1'b1, 8'h30, 1'b1);
    u_mst.stop();
    repeat (400) @(posedge clk);
    check(ana.hold, 1'b0);
    wrc(32'h08, 32'h55, RESP_OKAY);
    rdc(32'h08, 32'h61, RESP_OKAY);
    wrc(32'h00, 32'h10, RESP_OKAY);
    u_mst.start();
    xfer(AR, 1'b1, AR, 1'b0);
    xfer(8'hff, 1'b0, 8'h61, 1'b0);
    xfer(8'hff, 1'b1, 8'hb0, 1'b1);
    u_mst.stop();
    wrc(32'h00, 32'h13, RESP_OKAY);
    rdc(32'h0c, 32'h02, RESP_OKAY);
    ext_sel <= 1'b1;
    repeat (10) @(posedge clk);
    check(osc_oe_n, 1'b1);
    rdc(32'h0c, 32'h0a, RESP_OKAY);
    // Conversion clocked from the pin: channel 2 differential
    u_mst.start();
    xfer(AR, 1'b1, AR, 1'b0);
    xfer(8'hff, 1'b0, 8'hb0, 1'b0);
    xfer(8'hff, 1'b1, 8'h12, 1'b1);
    u_mst.stop();
    conclude();
  end
endmodule
